// File: core/keystream_bfield_xor_map.v
// Overview of operation
// - unprotected: data bit i uses segment bit i+40
// - half slot counts grow with j
// - unprotected full slot data bit counts
// - unprotected double slot data bit counts
// - single subfield: data bit i uses i+40
// - single subfield full slot encrypted counts
// - single subfield double slot encrypted counts
// - multisubfield: segment 40..103 covers data 0..63
// - segment bits 104..119 discarded over check field
// - cipher-control tail: segment 0..39 on A 8..47
// - subfield checks and X-field pass unencrypted
`timescale 1ns/100ps
`include "keystream_bfield_xor_map_defs.vh"

module keystream_bfield_xor_map
(
  // clock and reset
  input  wire                   clock_i,
  input  wire                   arst_n_i,
  // burst configuration, taken on burst_start_i
  input  wire                   burst_start_i,
  input  wire [1:0]             slot_format_i,
  input  wire [1:0]             modulation_i,
  input  wire [1:0]             bfield_format_i,
  input  wire [`KXM_J_W-1:0]    half_slot_j_i,
  input  wire                   cipher_control_tail_i,
  // bit stream in: one key stream segment bit and one field bit
  input  wire                   bit_valid_i,
  input  wire                   key_stream_segment_i,
  input  wire                   field_bit_i,
  // bit stream out
  output reg                    bit_valid_o,
  output reg                    field_bit_o,
  output reg                    key_applied_o
);

  // ****************************************
  // configuration and position state
  // ****************************************
  // latched burst configuration
  reg                    ct_q;
  reg [1:0]              fmt_q;
  reg [`KXM_IDX_W-1:0]   count_q;

  // position in the key stream segment and in the current subfield
  reg [`KXM_IDX_W-1:0]   kidx_q;
  reg [6:0]              sub_pos_q;

  // combinational decode of the count and of the key use
  reg [`KXM_IDX_W-1:0]   step_x_j;
  reg [`KXM_IDX_W-1:0]   half_count;
  reg [`KXM_IDX_W-1:0]   full_count;
  reg [`KXM_IDX_W-1:0]   double_count;
  reg [`KXM_IDX_W-1:0]   count_d;
  reg [`KXM_IDX_W-1:0]   data_idx;
  reg                    use_key;

  // ****************************************
  // half slot count: base plus step times j
  // ****************************************
  always @*
  begin
    step_x_j = (modulation_i == `KXM_MOD_2_4 || modulation_i == `KXM_MOD_4_4) ?
               ({{(`KXM_IDX_W-`KXM_J_W){1'b0}}, half_slot_j_i} * `KXM_STEP_4) :
               ({{(`KXM_IDX_W-`KXM_J_W){1'b0}}, half_slot_j_i} * `KXM_STEP_8);
    case (modulation_i)
      `KXM_MOD_2_4: half_count = `KXM_HALF_2_4 + step_x_j;
      `KXM_MOD_2_8: half_count = `KXM_HALF_2_8 + step_x_j;
      `KXM_MOD_4_4: half_count = `KXM_HALF_4_4 + step_x_j;
      default:      half_count = `KXM_HALF_8_8 + step_x_j;
    endcase
  end

  // ****************************************
  // full slot count: single subfield or unprotected
  // ****************************************
  always @*
  begin
    if (bfield_format_i == `KXM_FMT_SINGLE)
    begin
      case (modulation_i)
        `KXM_MOD_2_4: full_count = `KXM_SF_2_4;
        `KXM_MOD_2_8: full_count = `KXM_SF_2_8;
        `KXM_MOD_4_4: full_count = `KXM_SF_4_4;
        default:      full_count = `KXM_SF_8_8;
      endcase
    end
    else
    begin
      case (modulation_i)
        `KXM_MOD_2_4: full_count = `KXM_UF_2_4;
        `KXM_MOD_2_8: full_count = `KXM_UF_2_8;
        `KXM_MOD_4_4: full_count = `KXM_UF_4_4;
        default:      full_count = `KXM_UF_8_8;
      endcase
    end
  end

  // ****************************************
  // double slot count: single subfield or unprotected
  // ****************************************
  always @*
  begin
    if (bfield_format_i == `KXM_FMT_SINGLE)
    begin
      case (modulation_i)
        `KXM_MOD_2_4: double_count = `KXM_SD_2_4;
        `KXM_MOD_2_8: double_count = `KXM_SD_2_8;
        `KXM_MOD_4_4: double_count = `KXM_SD_4_4;
        default:      double_count = `KXM_SD_8_8;
      endcase
    end
    else
    begin
      case (modulation_i)
        `KXM_MOD_2_4: double_count = `KXM_UD_2_4;
        `KXM_MOD_2_8: double_count = `KXM_UD_2_8;
        `KXM_MOD_4_4: double_count = `KXM_UD_4_4;
        default:      double_count = `KXM_UD_8_8;
      endcase
    end
  end

  // ****************************************
  // data bit count chosen by slot format
  // ****************************************
  // the unused slot code falls back to the double slot count
  always @*
  begin
    case (slot_format_i)
      `KXM_SLOT_HALF: count_d = half_count;
      `KXM_SLOT_FULL: count_d = full_count;
      default:        count_d = double_count;
    endcase
  end

  // ****************************************
  // decide whether the current key bit is applied
  // ****************************************
  // past the data bit count every bit passes through unchanged
  always @*
  begin
    data_idx = kidx_q - `KXM_A_KEY_BITS;
    use_key  = 1'b0;
    if (kidx_q < `KXM_A_KEY_BITS)
      use_key = ct_q;
    else if (data_idx < count_q)
    begin
      if (fmt_q == `KXM_FMT_MULTI)
        use_key = (sub_pos_q < `KXM_SUB_DATA);
      else
        use_key = 1'b1;
    end
  end

  // ****************************************
  // burst configuration latched on start
  // ****************************************
  always @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      ct_q    <= 1'b0;
      fmt_q   <= `KXM_FMT_UNPROT;
      count_q <= {`KXM_IDX_W{1'b0}};
    end
    else if (burst_start_i)
    begin
      ct_q    <= cipher_control_tail_i;
      fmt_q   <= bfield_format_i;
      count_q <= count_d;
    end
  end

  // ****************************************
  // position in the segment and in the subfield
  // ****************************************
  // the index stops at its top value instead of wrapping into the tail prefix
  always @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      kidx_q    <= {`KXM_IDX_W{1'b0}};
      sub_pos_q <= 7'h00;
    end
    else if (burst_start_i)
    begin
      kidx_q    <= {`KXM_IDX_W{1'b0}};
      sub_pos_q <= 7'h00;
    end
    else if (bit_valid_i)
    begin
      if (kidx_q != {`KXM_IDX_W{1'b1}})
        kidx_q <= kidx_q + 12'h001;
      if (kidx_q >= `KXM_A_KEY_BITS)
        sub_pos_q <= (sub_pos_q == `KXM_SUB_LEN - 7'h01) ? 7'h00 :
                     sub_pos_q + 7'h01;
    end
  end

  // ****************************************
  // registered xor output, same path both directions
  // ****************************************
  // a pair that arrives together with the start strobe is dropped
  always @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      bit_valid_o   <= 1'b0;
      field_bit_o   <= 1'b0;
      key_applied_o <= 1'b0;
    end
    else
    begin
      bit_valid_o   <= bit_valid_i && !burst_start_i;
      field_bit_o   <= field_bit_i ^ (use_key & key_stream_segment_i);
      key_applied_o <= bit_valid_i && !burst_start_i && use_key;
    end
  end

endmodule

// File: core/keystream_bfield_xor_map_defs.vh
`ifndef KEYSTREAM_BFIELD_XOR_MAP_DEFS_VH
`define KEYSTREAM_BFIELD_XOR_MAP_DEFS_VH

// ****************************************
// widths
// ****************************************
`define KXM_IDX_W        12
`define KXM_J_W          8

// ****************************************
// slot format codes
// ****************************************
`define KXM_SLOT_HALF    2'h0
`define KXM_SLOT_FULL    2'h1
`define KXM_SLOT_DOUBLE  2'h2

// ****************************************
// modulation codes (A-field / B-field)
// ****************************************
`define KXM_MOD_2_4      2'h0
`define KXM_MOD_2_8      2'h1
`define KXM_MOD_4_4      2'h2
`define KXM_MOD_8_8      2'h3

// ****************************************
// B-field format codes
// ****************************************
`define KXM_FMT_UNPROT   2'h0
`define KXM_FMT_SINGLE   2'h1
`define KXM_FMT_MULTI    2'h2

// ****************************************
// key stream segment layout
// ****************************************
`define KXM_A_KEY_BITS   12'h028
`define KXM_SUB_LEN      7'h50
`define KXM_SUB_DATA     7'h40

// ****************************************
// half slot counts: base plus step times j
// ****************************************
`define KXM_HALF_2_4     12'h0A0
`define KXM_HALF_2_8     12'h0F0
`define KXM_HALF_4_4     12'h0E0
`define KXM_HALF_8_8     12'h170
`define KXM_STEP_4       12'h002
`define KXM_STEP_8       12'h003

// ****************************************
// unprotected full and double counts
// ****************************************
`define KXM_UF_2_4       12'h280
`define KXM_UF_2_8       12'h3C0
`define KXM_UF_4_4       12'h2C0
`define KXM_UF_8_8       12'h440
`define KXM_UD_2_4       12'h640
`define KXM_UD_2_8       12'h960
`define KXM_UD_4_4       12'h680
`define KXM_UD_8_8       12'h9E0

// ****************************************
// single subfield protected counts
// ****************************************
`define KXM_SF_2_4       12'h260
`define KXM_SF_2_8       12'h3A0
`define KXM_SF_4_4       12'h2A0
`define KXM_SF_8_8       12'h420
`define KXM_SD_2_4       12'h620
`define KXM_SD_2_8       12'h940
`define KXM_SD_4_4       12'h660
`define KXM_SD_8_8       12'h9C0

`endif

// File: test/keystream_source.sv
`timescale 1ns/100ps
module keystream_source
(
  // clock and reset
  input  wire clock_i,
  input  wire arst_n_i,
  // framing seen on the burst side
  input  wire burst_start_i,
  input  wire bit_valid_i,
  // segment bit and field bit for the current position
  output wire key_stream_segment_o,
  output wire field_bit_o
);
  reg [11:0] pos_q;
  // one segment per burst, index 0 first, one bit per taken pair
  always @(posedge clock_i or negedge arst_n_i)
    if (!arst_n_i)
      pos_q <= 12'h000;
    else if (burst_start_i)
      pos_q <= 12'h000;
    else if (bit_valid_i)
      pos_q <= pos_q + 12'h001;
  // unrelated patterns so a shifted index shows up at once
  assign key_stream_segment_o = pos_q[0] ^ pos_q[2] ^ pos_q[5];
  assign field_bit_o          = pos_q[1] ^ pos_q[3] ^ pos_q[6];
endmodule

// File: test/keystream_bfield_xor_map_properties.sv
`timescale 1ns/100ps
`include "keystream_bfield_xor_map_defs.vh"
module keystream_bfield_xor_map_checker
(
  // clock, reset and inputs
  input wire       clock_i, arst_n_i, burst_start_i, cipher_control_tail_i,
  input wire [1:0] slot_format_i, modulation_i, bfield_format_i,
  input wire [7:0] half_slot_j_i,
  input wire       bit_valid_i, key_stream_segment_i, field_bit_i,
  // outputs
  input wire       bit_valid_o, field_bit_o, key_applied_o
);
  reg  [11:0] k_q, o_q;
  reg  [1:0]  s_q, m_q, f_q;
  reg         ct_q;
  wire [11:0] i_w = o_q - 12'h028;
  wire        b_w = bit_valid_o && o_q >= 12'h028;
  // key index of the pair now at the outputs
  always @(posedge clock_i or negedge arst_n_i)
    if (!arst_n_i)
      {k_q, o_q, s_q, m_q, f_q, ct_q} <= 31'h0;
    else if (burst_start_i)
      {k_q, s_q, m_q, f_q, ct_q} <= {12'h000, slot_format_i, modulation_i,
                                     bfield_format_i, cipher_control_tail_i};
    else if (bit_valid_i)
      {k_q, o_q} <= {k_q + 12'h001, k_q};
  default clocking @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  a_pair_latency: assert property (bit_valid_i && !burst_start_i |=> bit_valid_o)
    else $error("pair not answered next cycle");
  a_start_drops: assert property (burst_start_i |=> !bit_valid_o)
    else $error("pair with start answered");
  a_xor_inverse: assert property (bit_valid_o |-> field_bit_o == ($past(field_bit_i)
    ^ (key_applied_o & $past(key_stream_segment_i))))
    else $error("output is not field xor key");
  a_tail_prefix: assert property (bit_valid_o && o_q < 12'h028 |-> key_applied_o == ct_q)
    else $error("tail key use wrong");
  a_low_data: assert property (b_w && f_q != 2'h2 && s_q != 2'h0 && i_w < 12'h260
    |-> key_applied_o)
    else $error("data bit left clear");
  a_full_limit: assert property (b_w && f_q == 2'h0 && s_q == 2'h1 && m_q == 2'h0
    |-> key_applied_o == (i_w < 12'h280))
    else $error("full slot count wrong");
  a_single_limit: assert property (b_w && f_q == 2'h1 && s_q == 2'h1 && m_q == 2'h0
    |-> key_applied_o == (i_w < 12'h260))
    else $error("single full count wrong");
  a_subfield_data: assert property (b_w && f_q == 2'h2 && i_w < 12'h040 |-> key_applied_o)
    else $error("subfield data left clear");
  a_check_discard: assert property (b_w && f_q == 2'h2 && i_w >= 12'h040
    && i_w < 12'h050 |-> !key_applied_o)
    else $error("check field ciphered");
  c_tail: cover property (bit_valid_o && o_q < 12'h028 && key_applied_o);
  c_check: cover property (b_w && f_q == 2'h2 && !key_applied_o);
  c_start: cover property (burst_start_i ##1 bit_valid_i);
endmodule
bind keystream_bfield_xor_map keystream_bfield_xor_map_checker chk_u
(
  .clock_i(clock_i), .arst_n_i(arst_n_i), .burst_start_i(burst_start_i),
  .cipher_control_tail_i(cipher_control_tail_i), .slot_format_i(slot_format_i),
  .modulation_i(modulation_i), .bfield_format_i(bfield_format_i),
  .half_slot_j_i(half_slot_j_i), .bit_valid_i(bit_valid_i),
  .key_stream_segment_i(key_stream_segment_i), .field_bit_i(field_bit_i),
  .bit_valid_o(bit_valid_o), .field_bit_o(field_bit_o), .key_applied_o(key_applied_o)
);

// File: test/test_keystream_bfield_xor_map.sv
`timescale 1ns/100ps
`include "keystream_bfield_xor_map_defs.vh"
module test_keystream_bfield_xor_map;
  reg         clock_i = 1'b0, arst_n_i = 1'b0, start_i = 1'b0, ct_i = 1'b0, valid_i = 1'b0;
  reg  [1:0]  slot_i = 2'h0, mod_i = 2'h0, fmt_i = 2'h0;
  wire        key_w, fld_w, valid_o, fld_o, applied_o;
  reg         kq, fq, ap;
  reg  [7:0]  j_i = 8'h05;
  // expected counts per modulation code, code 0 in the low twelve bits
  localparam [47:0] hb = {12'h170, 12'h0E0, 12'h0F0, 12'h0A0};
  localparam [47:0] uf = {12'h440, 12'h2C0, 12'h3C0, 12'h280};
  localparam [47:0] ud = {12'h9E0, 12'h680, 12'h960, 12'h640};
  localparam [47:0] sf = {12'h420, 12'h2A0, 12'h3A0, 12'h260};
  localparam [47:0] sd = {12'h9C0, 12'h660, 12'h940, 12'h620};
  integer     errors = 0, num_checks = 0, cycles = 0, s, m;
  // clock and watchdog
  always #5 clock_i = ~clock_i;
  always @(posedge clock_i)
  begin
    cycles = cycles + 1;
    if (cycles == 60000)
    begin
      errors = errors + 1;
      final_report;
    end
  end
  keystream_bfield_xor_map dut
  (
    .clock_i(clock_i), .arst_n_i(arst_n_i), .burst_start_i(start_i),
    .slot_format_i(slot_i), .modulation_i(mod_i), .bfield_format_i(fmt_i),
    .half_slot_j_i(j_i), .cipher_control_tail_i(ct_i), .bit_valid_i(valid_i),
    .key_stream_segment_i(key_w), .field_bit_i(fld_w),
    .bit_valid_o(valid_o), .field_bit_o(fld_o), .key_applied_o(applied_o)
  );
  keystream_source src
  (
    .clock_i(clock_i), .arst_n_i(arst_n_i), .burst_start_i(start_i),
    .bit_valid_i(valid_i), .key_stream_segment_o(key_w), .field_bit_o(fld_w)
  );
  task chk(input logic [11:0] seen, input logic [11:0] exp, input [63:0] what);
  begin
    num_checks = num_checks + 1;
    if (seen !== exp)
    begin
      errors = errors + 1;
      $display("[FAIL] %0s expected %0h seen %0h", what, exp, seen);
    end
  end
  endtask
  // one burst of cnt data bits plus the tail prefix and one bit beyond
  task burst(input [1:0] sl, input [1:0] md, input [1:0] fm, input c, input integer cnt);
    integer k;
  begin
    @(posedge clock_i);
    {start_i, slot_i, mod_i, fmt_i, ct_i} <= {1'b1, sl, md, fm, c};
    @(posedge clock_i);
    start_i <= 1'b0;
    valid_i <= 1'b1;
    for (k = 0; k <= cnt + 41; k = k + 1)
    begin
      @(negedge clock_i);
      if (k > 0)
      begin
        ap = (k < 41) ? c : ((k - 41 < cnt) && (fm != `KXM_FMT_MULTI || (k - 41) % 80 < 64));
        chk(valid_o, 1, "valid");
        chk(applied_o, ap, "applied");
        chk(fld_o, fq ^ (ap & kq), "field");
      end
      kq = key_w;
      fq = fld_w;
      @(posedge clock_i);
      if (k == cnt + 40)
        valid_i <= 1'b0;
    end
    @(negedge clock_i);
    chk(valid_o, 0, "idle");
  end
  endtask
  // every slot and modulation for one format
  task t_formats(input [1:0] fm, input c, input [7:0] jv);
  begin
    @(posedge clock_i);
    j_i <= jv;
    for (s = 0; s < 3; s = s + 1)
      for (m = 0; m < 4; m = m + 1)
        burst(s[1:0], m[1:0], fm, c,
          s == 0 ? hb[m*12 +: 12] + (m % 2 ? 3 * jv : 2 * jv) :
          fm == `KXM_FMT_SINGLE ? (s == 1 ? sf[m*12 +: 12] : sd[m*12 +: 12]) :
          (s == 1 ? uf[m*12 +: 12] : ud[m*12 +: 12]));
  end
  endtask
  // reset in mid burst clears the outputs, then a fresh burst runs clean
  task t_reset;
  begin
    @(posedge clock_i);
    {start_i, slot_i, mod_i, fmt_i, ct_i} <= {1'b1, `KXM_SLOT_FULL, `KXM_MOD_2_4,
                                              `KXM_FMT_UNPROT, 1'b1};
    @(posedge clock_i);
    start_i <= 1'b0;
    valid_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    @(negedge clock_i);
    chk(applied_o, 1, "pre_rst");
    @(posedge clock_i);
    arst_n_i <= 1'b0;
    valid_i  <= 1'b0;
    @(negedge clock_i);
    chk(valid_o, 0, "rst_vld");
    chk(applied_o, 0, "rst_key");
    repeat (2) @(posedge clock_i);
    arst_n_i <= 1'b1;
    burst(`KXM_SLOT_HALF, `KXM_MOD_2_4, `KXM_FMT_UNPROT, 1'b0, hb[11:0] + 2 * j_i);
  end
  endtask
  task final_report;
  begin
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  end
  endtask
  // main sequence
  initial
  begin
    repeat (16) @(posedge clock_i);
    chk(valid_o, 0, "reset");
    arst_n_i <= 1'b1;
    t_formats(`KXM_FMT_UNPROT, 1'b0, 8'h05);
    t_formats(`KXM_FMT_SINGLE, 1'b1, 8'h2A);
    t_reset;
    burst(`KXM_SLOT_FULL, `KXM_MOD_4_4, `KXM_FMT_MULTI, 1'b1, 704);
    final_report;
  end
endmodule
